// ---- design/eiwvp_pkg.sv ----
// constants, register map and types for the external request, wake and vector block
package eiwvp_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int N_LINES = 16;
  localparam int N_PERI = 7;
  localparam int N_SRC = N_LINES + N_PERI;
  localparam int PRIO_W = 3;
  localparam int PRIO_STRIDE = 4;
  localparam int SENSE_W = 2;

  // ********************
  // register offsets
  // ********************
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SENSE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LINE_EN = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PEND = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_WAKE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PRIO_LO = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PRIO_HI = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PRIO_MOD = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_PERI_EN = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_STAT_CLR = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_STAT_EN = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_STATE = 8'h30;

  // ********************
  // field positions and reset values
  // ********************
  localparam int CTRL_NMI_EDGE = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_STBY = 3;
  localparam logic [1:0] MODE_DEFAULT = 2'h0;
  localparam logic [1:0] MODE_LEVELS = 2'h2;
  localparam int STAT_NMI = 0;
  localparam int STAT_WAKE = 1;
  localparam int N_STAT = 2;
  localparam logic [DATA_W-1:0] PRIO_LINE_MASK = 32'h77777777;
  localparam logic [DATA_W-1:0] PRIO_MOD_MASK = 32'h00077777;
  localparam logic [DATA_W-1:0] PRIO_RST = 32'h77777777;
  localparam logic [DATA_W-1:0] PRIO_MOD_RST = 32'h00077777;
  localparam logic [PRIO_W-1:0] LEVEL_TOP = 3'h7;

  // ********************
  // vectors
  // ********************
  localparam logic [7:0] VEC_NMI = 8'h07;
  localparam logic [7:0] VEC_LINE0 = 8'h10;
  localparam int VEC_SHIFT = 2;
  // transfer end, watchdog, refresh, converter, timer0 a/b/c (lsb = first)
  localparam logic [8*N_PERI-1:0] PERI_VEC = {8'h2a, 8'h29, 8'h28, 8'h26, 8'h23, 8'h21, 8'h20};
  // module index of each peripheral source into the module priority register
  localparam logic [PRIO_W*N_PERI-1:0] PERI_MOD = {3'h4, 3'h4, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};

  // ********************
  // timing
  // ********************
  localparam int CLK_NS = 25;
  localparam int SETTLE_NS = 10000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    SENSE_LOW = 2'b00,
    SENSE_FALL = 2'b01,
    SENSE_RISE = 2'b10,
    SENSE_BOTH = 2'b11
  } eiwvp_sense_t;

  typedef enum logic [1:0] {
    PS_RUN = 2'b00,
    PS_STBY = 2'b01,
    PS_SETTLE = 2'b10
  } eiwvp_pstate_t;
endpackage : eiwvp_pkg

// ---- design/eiwvp_det_if.sv ----
// bundle between the controller and the per-line detector
`timescale 1ns/1ps
interface eiwvp_det_if #(
  parameter int N = 16
);
  logic [N-1:0] pin;
  logic [2*N-1:0] sense;
  logic [N-1:0] sample_en;
  logic [N-1:0] hit;
  modport det (input pin, input sense, input sample_en, output hit);
  modport ctl (output pin, output sense, output sample_en, input hit);
endinterface : eiwvp_det_if

// ---- design/eiwvp_line_det.sv ----
// per-line level and edge detector for the maskable request lines
`timescale 1ns/1ps
module eiwvp_line_det
  import eiwvp_pkg::*;
#(
  parameter int N = 16
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  eiwvp_det_if.det det
);
  // decode one line's sense code against previous and present pin level
  function automatic logic sense_hit(input logic [1:0] code, input logic prev, input logic cur);
    case (code)
      SENSE_LOW: sense_hit = ~cur;
      SENSE_FALL: sense_hit = prev & ~cur;
      SENSE_RISE: sense_hit = ~prev & cur;
      SENSE_BOTH: sense_hit = prev ^ cur;
      default: sense_hit = 1'b0;
    endcase
  endfunction : sense_hit

  logic [N-1:0] prev_q;

  // previous pin level, idle high
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      prev_q <= '1;
    end else begin
      prev_q <= det.pin;
    end
  end

  // one detector per line, gated by the sampling enable
  for (genvar g = 0; g < N; g++) begin : g_line
    assign det.hit[g] = det.sample_en[g] &
      sense_hit(det.sense[SENSE_W*g +: SENSE_W], prev_q[g], det.pin[g]);
  end
endmodule : eiwvp_line_det

// ---- design/eiwvp_ctrl.sv ----
// external request, standby wake and vector priority controller
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
module eiwvp_ctrl
  import eiwvp_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  input wire logic nmi_pin_i,
  input wire logic [N_LINES-1:0] line_pin_i,
  input wire logic [N_PERI-1:0] peri_flag_i,
  input wire logic cpu_mask_i,
  input wire logic [PRIO_W-1:0] cpu_mask_level_i,
  input wire logic cpu_ack_i,
  output logic cpu_req_o,
  output logic [7:0] cpu_vec_o,
  output logic [15:0] cpu_vec_addr_o,
  output logic [PRIO_W-1:0] cpu_level_o,
  output logic [N_SRC-1:0] xfer_req_o,
  output logic standby_o,
  output logic irq_o
);
  // width of the settling down-counter
  localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);

  // ********************
  // decode helpers
  // ********************
  // priority level of a source, lines own fields, peripherals their module field
  function automatic logic [PRIO_W-1:0] src_level(input int idx, input logic [DATA_W-1:0] lo,
                                                  input logic [DATA_W-1:0] hi, input logic [DATA_W-1:0] md);
    int m;
    m = 0;
    if (idx < N_LINES / 2) begin
      src_level = lo[PRIO_STRIDE*idx +: PRIO_W];
    end else if (idx < N_LINES) begin
      src_level = hi[PRIO_STRIDE*(idx-N_LINES/2) +: PRIO_W];
    end else begin
      m = int'(PERI_MOD[PRIO_W*(idx-N_LINES) +: PRIO_W]);
      src_level = md[PRIO_STRIDE*m +: PRIO_W];
    end
  endfunction : src_level

  // vector number of a source; reserved numbers are absent from the table
  function automatic logic [7:0] src_vec(input int idx);
    if (idx < N_LINES) begin
      src_vec = 8'(int'(VEC_LINE0) + idx);
    end else begin
      src_vec = PERI_VEC[8*(idx-N_LINES) +: 8];
    end
  endfunction : src_vec

  // ********************
  // state
  // ********************
  // configuration, flags and power state registers
  logic nmi_edge_q;
  logic [1:0] mode_q;
  logic [2*N_LINES-1:0] sense_q;
  logic [N_LINES-1:0] line_en_q;
  logic [N_LINES-1:0] pend_q;
  logic [N_LINES-1:0] wake_q;
  logic [DATA_W-1:0] prio_lo_q;
  logic [DATA_W-1:0] prio_hi_q;
  logic [DATA_W-1:0] prio_md_q;
  logic [N_PERI-1:0] peri_en_q;
  logic [N_STAT-1:0] stat_q;
  logic [N_STAT-1:0] stat_en_q;
  logic nmi_pend_q;
  logic nmi_prev_q;
  eiwvp_pstate_t pstate_q;
  logic [CNT_W-1:0] settle_q;
  // combinational helpers
  logic wr_ctrl;
  logic wr_pend;
  logic nmi_hit;
  logic wake_req;
  logic settle_done;
  logic [N_STAT-1:0] stat_evt;
  logic [N_SRC-1:0] src_req;
  logic best_found;
  logic [7:0] best_vec;
  logic [PRIO_W-1:0] best_lvl;
  logic best_ok;

  // bundle toward the per-line detector
  eiwvp_det_if #(.N(N_LINES)) det ();

  // pad level is taken whatever the pin direction
  assign det.pin = line_pin_i;
  assign det.sense = sense_q;
  // in standby only wake-enabled lines are sampled
  assign det.sample_en = (pstate_q == PS_RUN) ? '1 : wake_q;

  eiwvp_line_det #(.N(N_LINES)) u_det (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .det(det)
  );

  // register write decodes
  assign wr_ctrl = reg_wr_i && (reg_addr_i == OFS_CTRL);
  assign wr_pend = reg_wr_i && (reg_addr_i == OFS_PEND);

  // ********************
  // configuration registers
  // ********************
  // software-written control, sense, enables, wake and levels
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      nmi_edge_q <= 1'b0;
      mode_q <= MODE_DEFAULT;
      sense_q <= '0;
      line_en_q <= '0;
      wake_q <= '0;
      prio_lo_q <= PRIO_RST;
      prio_hi_q <= PRIO_RST;
      prio_md_q <= PRIO_MOD_RST;
      peri_en_q <= '0;
      stat_en_q <= '0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        OFS_CTRL: begin
          nmi_edge_q <= reg_wdata_i[CTRL_NMI_EDGE];
          mode_q <= reg_wdata_i[CTRL_MODE_LSB +: 2];
        end
        OFS_SENSE: sense_q <= reg_wdata_i[2*N_LINES-1:0];
        OFS_LINE_EN: line_en_q <= reg_wdata_i[N_LINES-1:0];
        OFS_WAKE: wake_q <= reg_wdata_i[N_LINES-1:0];
        OFS_PRIO_LO: prio_lo_q <= reg_wdata_i & PRIO_LINE_MASK;
        OFS_PRIO_HI: prio_hi_q <= reg_wdata_i & PRIO_LINE_MASK;
        OFS_PRIO_MOD: prio_md_q <= reg_wdata_i & PRIO_MOD_MASK;
        OFS_PERI_EN: peri_en_q <= reg_wdata_i[N_PERI-1:0];
        OFS_STAT_EN: stat_en_q <= reg_wdata_i[N_STAT-1:0];
        default: ;
      endcase
    end
  end

  // ********************
  // pending flags
  // ********************
  // write 0 clears, a same-cycle detection wins
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pend_q <= '0;
    end else if (wr_pend) begin
      pend_q <= (pend_q & reg_wdata_i[N_LINES-1:0]) | det.hit;
    end else begin
      pend_q <= pend_q | det.hit;
    end
  end

  // ********************
  // non-maskable input
  // ********************
  // edge match on the selected polarity
  assign nmi_hit = nmi_edge_q ? (~nmi_prev_q & nmi_pin_i) : (nmi_prev_q & ~nmi_pin_i);

  // edge detect and pending until the cpu takes vector 7
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      nmi_prev_q <= 1'b1;
      nmi_pend_q <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_pin_i;
      if (nmi_hit) begin
        nmi_pend_q <= 1'b1;
      end else if (cpu_ack_i && cpu_req_o && cpu_vec_o == VEC_NMI) begin
        nmi_pend_q <= 1'b0;
      end
    end
  end

  // ********************
  // software standby
  // ********************
  // wake sources: the non-maskable edge or a wake-enabled line
  assign wake_req = nmi_hit || (|(det.hit & wake_q));
  assign settle_done = (pstate_q == PS_SETTLE) && (settle_q == '0);

  // enter on control write, leave after the settling count
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pstate_q <= PS_RUN;
      settle_q <= '0;
    end else begin
      case (pstate_q)
        PS_RUN: begin
          if (wr_ctrl && reg_wdata_i[CTRL_STBY]) begin
            pstate_q <= PS_STBY;
          end
        end
        PS_STBY: begin
          if (wake_req) begin
            pstate_q <= PS_SETTLE;
            settle_q <= CNT_W'(SETTLE_CYCLES - 1);
          end
        end
        PS_SETTLE: begin
          if (settle_q == '0) begin
            pstate_q <= PS_RUN;
          end else begin
            settle_q <= settle_q - 1'b1;
          end
        end
        default: pstate_q <= PS_RUN;
      endcase
    end
  end

  // standby covers the settling phase too
  assign standby_o = (pstate_q != PS_RUN);

  // ********************
  // arbitration
  // ********************
  // requests gated by their own enables only
  assign src_req = {peri_flag_i & peri_en_q, pend_q & line_en_q};

  // pick the winner; strict greater keeps ties on the lower vector
  always_comb begin
    logic [PRIO_W-1:0] lvl;
    lvl = '0;
    best_found = 1'b0;
    best_vec = '0;
    best_lvl = '0;
    for (int i = 0; i < N_SRC; i++) begin
      lvl = (mode_q == MODE_LEVELS) ? src_level(i, prio_lo_q, prio_hi_q, prio_md_q) : '0;
      if (src_req[i] && (!best_found || lvl > best_lvl)) begin
        best_found = 1'b1;
        best_vec = src_vec(i);
        best_lvl = lvl;
      end
    end
    if (mode_q == MODE_LEVELS) begin
      best_ok = best_found && (best_lvl > cpu_mask_level_i);
    end else begin
      best_ok = best_found && !cpu_mask_i;
    end
  end

  // registered request, vector and entry address toward the cpu
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cpu_req_o <= 1'b0;
      cpu_vec_o <= '0;
      cpu_vec_addr_o <= '0;
      cpu_level_o <= '0;
    end else if (nmi_pend_q && !(cpu_ack_i && cpu_req_o && cpu_vec_o == VEC_NMI)) begin
      cpu_req_o <= 1'b1;
      cpu_vec_o <= VEC_NMI;
      cpu_vec_addr_o <= 16'(VEC_NMI) << VEC_SHIFT;
      cpu_level_o <= LEVEL_TOP;
    end else begin
      cpu_req_o <= best_ok;
      cpu_vec_o <= best_ok ? best_vec : '0;
      cpu_vec_addr_o <= best_ok ? (16'(best_vec) << VEC_SHIFT) : '0;
      cpu_level_o <= best_ok ? best_lvl : '0;
    end
  end

  // transfer controller requests bypass mode and mask
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      xfer_req_o <= '0;
    end else begin
      xfer_req_o <= src_req;
    end
  end

  // ********************
  // event status and interrupt
  // ********************
  // status events: non-maskable edge, end of settling
  assign stat_evt = {settle_done, nmi_hit};

  // sticky status; a new event wins over the clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      stat_q <= '0;
    end else if (reg_wr_i && reg_addr_i == OFS_STAT_CLR) begin
      stat_q <= (stat_q & ~reg_wdata_i[N_STAT-1:0]) | stat_evt;
    end else begin
      stat_q <= stat_q | stat_evt;
    end
  end

  // level interrupt while an enabled status bit is set
  assign irq_o = |(stat_q & stat_en_q);

  // ********************
  // read port
  // ********************
  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_CTRL: reg_rdata_o <= DATA_W'({mode_q, nmi_edge_q}) << CTRL_NMI_EDGE;
        OFS_SENSE: reg_rdata_o <= DATA_W'(sense_q);
        OFS_LINE_EN: reg_rdata_o <= DATA_W'(line_en_q);
        OFS_PEND: reg_rdata_o <= DATA_W'(pend_q);
        OFS_WAKE: reg_rdata_o <= DATA_W'(wake_q);
        OFS_PRIO_LO: reg_rdata_o <= prio_lo_q;
        OFS_PRIO_HI: reg_rdata_o <= prio_hi_q;
        OFS_PRIO_MOD: reg_rdata_o <= prio_md_q;
        OFS_PERI_EN: reg_rdata_o <= DATA_W'(peri_en_q);
        OFS_STAT: reg_rdata_o <= DATA_W'(stat_q);
        OFS_STAT_EN: reg_rdata_o <= DATA_W'(stat_en_q);
        OFS_STATE: reg_rdata_o <= DATA_W'({nmi_pend_q, pstate_q});
        default: reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end
endmodule : eiwvp_ctrl

// ---- dv/eiwvp_ctrl_asserts.sv ----
// port checker for the request, wake and vector controller
`timescale 1ns/1ps
module eiwvp_ctrl_asserts
  import eiwvp_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic [N_PERI-1:0] peri_flag_i,
  input wire logic cpu_req_o,
  input wire logic [7:0] cpu_vec_o,
  input wire logic [15:0] cpu_vec_addr_o,
  input wire logic [PRIO_W-1:0] cpu_level_o,
  input wire logic [N_SRC-1:0] xfer_req_o,
  input wire logic standby_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // ********************
  // port relations
  // ********************
  rdata_idle_zero_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data outside read slot");
  vec_addr_scale_a: assert property (cpu_req_o |-> cpu_vec_addr_o == {6'h00, cpu_vec_o, 2'b00})
    else $error("vector entry not vector times four");
  vec_reserved_a: assert property (cpu_req_o |-> !(cpu_vec_o inside {8'h22, 8'h24, 8'h25, 8'h27}))
    else $error("reserved vector raised");
  vec_range_a: assert property (cpu_req_o |-> cpu_vec_o == VEC_NMI || (cpu_vec_o >= 8'h10 && cpu_vec_o <= 8'h2a))
    else $error("vector outside handled range");
  nmi_top_level_a: assert property (cpu_req_o && cpu_vec_o == VEC_NMI |-> cpu_level_o == LEVEL_TOP)
    else $error("non-maskable request not at top level");
  peri_gate_a: assert property ((xfer_req_o[N_SRC-1:N_LINES] & ~$past(peri_flag_i)) == '0)
    else $error("transfer request without peripheral flag");
  stby_entry_a: assert property ($rose(standby_o) |-> $past(reg_wr_i && reg_addr_i == OFS_CTRL && reg_wdata_i[CTRL_STBY]))
    else $error("standby entered without control write");
  settle_time_a: assert property ($fell(standby_o) |-> $past(standby_o, SETTLE_CYCLES))
    else $error("standby left before settling");
endmodule : eiwvp_ctrl_asserts

bind eiwvp_ctrl eiwvp_ctrl_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_eiwvp_ctrl_asserts (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .peri_flag_i(peri_flag_i),
  .cpu_req_o(cpu_req_o), .cpu_vec_o(cpu_vec_o), .cpu_vec_addr_o(cpu_vec_addr_o),
  .cpu_level_o(cpu_level_o), .xfer_req_o(xfer_req_o), .standby_o(standby_o));

// ---- dv/eiwvp_cpu_model.sv ----
// cpu core model that accepts offered requests promptly or slowly
`timescale 1ns/1ps
module eiwvp_cpu_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ack_en_i,
  input wire logic slow_i,
  input wire logic cpu_req_i,
  output logic cpu_ack_o
);
  logic [1:0] wait_q;
  // one-cycle accept pulse, no mask check since the core always takes it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !ack_en_i || !cpu_req_i || cpu_ack_o) begin
      cpu_ack_o <= 1'b0;
      wait_q <= 2'h0;
    end else if (wait_q == (slow_i ? 2'h3 : 2'h0)) begin
      cpu_ack_o <= 1'b1;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule : eiwvp_cpu_model

// ---- dv/eiwvp_ctrl_bench.sv ----
// self-checking bench for the request, wake and vector controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module eiwvp_ctrl_bench;
  import eiwvp_pkg::*;
  localparam int SETTLE = 4;
  logic clk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, nmi_pin_i = 1, cpu_mask_i = 0;
  logic [7:0] reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0, d;
  logic [15:0] line_pin_i = 16'hffff;
  logic [6:0] peri_flag_i = '0;
  logic [2:0] cpu_mask_level_i = '0, cpu_level_o;
  logic cpu_ack_i, cpu_req_o, standby_o, irq_o, ack_en = 0, slow = 0;
  logic [31:0] reg_rdata_o;
  logic [7:0] cpu_vec_o;
  logic [15:0] cpu_vec_addr_o;
  logic [22:0] xfer_req_o;
  logic [7:0] pv [7] = '{8'h20, 8'h21, 8'h23, 8'h26, 8'h28, 8'h29, 8'h2a};
  int err_count = 0, n_compared = 0;
  eiwvp_ctrl #(.SETTLE_CYCLES(SETTLE)) u_eiwvp_ctrl (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .nmi_pin_i(nmi_pin_i), .line_pin_i(line_pin_i), .peri_flag_i(peri_flag_i),
    .cpu_mask_i(cpu_mask_i), .cpu_mask_level_i(cpu_mask_level_i), .cpu_ack_i(cpu_ack_i),
    .cpu_req_o(cpu_req_o), .cpu_vec_o(cpu_vec_o), .cpu_vec_addr_o(cpu_vec_addr_o),
    .cpu_level_o(cpu_level_o), .xfer_req_o(xfer_req_o), .standby_o(standby_o), .irq_o(irq_o));
  eiwvp_cpu_model u_eiwvp_cpu_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ack_en_i(ack_en),
    .slow_i(slow), .cpu_req_i(cpu_req_o), .cpu_ack_o(cpu_ack_i));
  // 40 mhz clock
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= v;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    reg_rd_i <= 1'b1; reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask : rd
  task automatic final_report;
    $display("compares %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // wake register reset value, width and an unmapped read
  task automatic t_regs;
    rd(OFS_WAKE, d); `CHK("wake rst", 32'h0, d)
    wr(OFS_WAKE, 32'hffffa5c3);
    rd(OFS_WAKE, d); `CHK("wake rw", 32'h0000a5c3, d)
    rd(8'h3c, d); `CHK("unmapped", 32'h0, d)
    rd(OFS_PRIO_MOD, d); `CHK("mod lvl rst", PRIO_MOD_RST, d)
    wr(OFS_WAKE, 32'h0);
  endtask : t_regs
  // every sense mode on its own line, then release and clear
  task automatic t_sense;
    for (int m = 0; m < 4; m++) begin
      int n = 3 * m + 1;
      logic [31:0] b = 32'h1 << n;
      wr(OFS_SENSE, 32'(m) << (2 * n)); wr(OFS_LINE_EN, b);
      @(posedge clk_i); line_pin_i[n] <= 1'b0;
      tick(3); rd(OFS_PEND, d); `CHK("pend on low", (m == 2) ? 32'h0 : b, d)
      @(posedge clk_i); line_pin_i[n] <= 1'b1;
      tick(3); `CHK("line req", 1'b1, cpu_req_o)
      `CHK("line vec", 8'(16 + n), cpu_vec_o)
      `CHK("line addr", 16'((16 + n) * 4), cpu_vec_addr_o)
      wr(OFS_PEND, ~b); tick(2); rd(OFS_PEND, d); `CHK("pend clr", 32'h0, d)
      `CHK("req gone", 1'b0, cpu_req_o)
    end
  endtask : t_sense
  // default order, then levels with refusal and a tie
  task automatic t_prio;
    wr(OFS_SENSE, 32'h410); wr(OFS_LINE_EN, 32'h24);
    @(posedge clk_i); line_pin_i[2] <= 1'b0; line_pin_i[5] <= 1'b0;
    tick(3); `CHK("dflt vec", 8'h12, cpu_vec_o)
    wr(OFS_CTRL, 32'h4); wr(OFS_PRIO_LO, 32'h77677377);
    tick(2); `CHK("lvl vec", 8'h15, cpu_vec_o)
    `CHK("lvl out", 3'h6, cpu_level_o)
    @(posedge clk_i); cpu_mask_level_i <= 3'h6;
    tick(2); `CHK("masked", 1'b0, cpu_req_o)
    `CHK("xfer lines", 16'h0024, xfer_req_o[15:0])
    @(posedge clk_i); cpu_mask_level_i <= 3'h0;
    wr(OFS_PRIO_LO, 32'h77377377);
    tick(2); `CHK("tie vec", 8'h12, cpu_vec_o)
    @(posedge clk_i); line_pin_i <= 16'hffff;
    wr(OFS_PEND, 32'h0); wr(OFS_CTRL, 32'h0); wr(OFS_PRIO_LO, PRIO_RST);
  endtask : t_prio
  // each peripheral vector, transfer path under mask, enable gating
  task automatic t_peri;
    wr(OFS_PERI_EN, 32'h7f);
    for (int k = 0; k < 7; k++) begin
      @(posedge clk_i); peri_flag_i <= 7'(1 << k);
      tick(3); `CHK("peri vec", pv[k], cpu_vec_o)
      `CHK("peri addr", {6'h00, pv[k], 2'b00}, cpu_vec_addr_o)
    end
    @(posedge clk_i); cpu_mask_i <= 1'b1; peri_flag_i <= 7'h7f;
    tick(3); `CHK("xfer masked", 7'h7f, xfer_req_o[22:16])
    `CHK("cpu masked", 1'b0, cpu_req_o)
    wr(OFS_PERI_EN, 32'h0); tick(2); `CHK("peri off", 7'h0, xfer_req_o[22:16])
    @(posedge clk_i); peri_flag_i <= '0; cpu_mask_i <= 1'b0;
  endtask : t_peri
  // both edge selections under full mask, accept and status clear
  task automatic t_nmi;
    wr(OFS_STAT_EN, 32'h1);
    @(posedge clk_i); cpu_mask_i <= 1'b1; cpu_mask_level_i <= 3'h7;
    for (int e = 1; e >= 0; e--) begin
      wr(OFS_CTRL, 32'h4 | 32'(e));
      @(posedge clk_i); nmi_pin_i <= !e[0];
      tick(3); `CHK("nmi wrong edge", 1'b0, cpu_req_o)
      @(posedge clk_i); nmi_pin_i <= e[0];
      tick(3); `CHK("nmi vec", VEC_NMI, cpu_vec_o)
      `CHK("nmi addr", 16'h001c, cpu_vec_addr_o)
      `CHK("nmi irq", 1'b1, irq_o)
      rd(OFS_STAT, d); `CHK("nmi stat", 32'h1, d)
      @(posedge clk_i); ack_en <= 1'b1; slow <= e[0];
      tick(8); `CHK("nmi taken", 1'b0, cpu_req_o)
      @(posedge clk_i); ack_en <= 1'b0;
      wr(OFS_STAT_CLR, 32'h1); tick(1); `CHK("irq clr", 1'b0, irq_o)
    end
    wr(OFS_CTRL, 32'h0);
    @(posedge clk_i); cpu_mask_i <= 1'b0; cpu_mask_level_i <= 3'h0;
  endtask : t_nmi
  // bounded wait for the end of standby; a timeout ends the run
  task automatic wait_run(output int n);
    for (n = 0; n < 40 && standby_o !== 1'b0; n++) tick(1);
    if (standby_o !== 1'b0) begin
      err_count++;
      final_report();
    end
  endtask : wait_run
  // unselected line ignored in standby, selected line and non-maskable pin wake after settling
  task automatic t_stby;
    int i;
    wr(OFS_SENSE, 32'h0); wr(OFS_WAKE, 32'h10); wr(OFS_CTRL, 32'h8);
    tick(1); `CHK("stby on", 1'b1, standby_o)
    rd(OFS_STATE, d); `CHK("stby state", 32'h1, d)
    @(posedge clk_i); line_pin_i[3] <= 1'b0;
    tick(6); `CHK("no wake", 1'b1, standby_o)
    @(posedge clk_i); line_pin_i[3] <= 1'b1;
    @(posedge clk_i); line_pin_i[4] <= 1'b0;
    wait_run(i);
    `CHK("settle long", 1'b1, i >= SETTLE)
    @(posedge clk_i); line_pin_i[4] <= 1'b1;
    rd(OFS_PEND, d); `CHK("pend wake", 32'h10, d)
    rd(OFS_STAT, d); `CHK("wake stat", 32'h2, d)
    wr(OFS_PEND, 32'h0); wr(OFS_STAT_CLR, 32'h3);
    @(posedge clk_i); nmi_pin_i <= 1'b1;
    wr(OFS_CTRL, 32'h8);
    @(posedge clk_i); nmi_pin_i <= 1'b0;
    wait_run(i);
    `CHK("nmi settle", 1'b1, i >= SETTLE)
    rd(OFS_STAT, d); `CHK("nmi wake stat", 32'h3, d)
    `CHK("nmi wake vec", VEC_NMI, cpu_vec_o)
    @(posedge clk_i); ack_en <= 1'b1;
    tick(3); `CHK("nmi wake taken", 1'b0, cpu_req_o)
    @(posedge clk_i); ack_en <= 1'b0; nmi_pin_i <= 1'b1;
    wr(OFS_STAT_CLR, 32'h3);
  endtask : t_stby
  // reset, scenarios, verdict
  initial begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_sense();
    t_prio();
    t_peri();
    t_nmi();
    t_stby();
    final_report();
  end
endmodule : eiwvp_ctrl_bench
